// ---- common/gpa_pkg.sv ----
// shared constants and types for the port a / port b pin block
package gpa_pkg;

    // byte offsets inside the block's window
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_PA_OTYPE = 12'h000;
    localparam logic [11:0] OFS_PA_DIR = 12'h004;
    localparam logic [11:0] OFS_PA_DATA = 12'h008;
    localparam logic [11:0] OFS_PA_PULLUP = 12'h00C;
    localparam logic [11:0] OFS_PA_PINS = 12'h010;
    localparam logic [11:0] OFS_SER_ROUTE = 12'h014;
    localparam logic [11:0] OFS_PB_DIR = 12'h020;
    localparam logic [11:0] OFS_PB_DATA = 12'h024;
    localparam logic [11:0] OFS_PB_PINS = 12'h028;

    // values after reset
    localparam logic [3:0] RST_PA = 4'h0;
    localparam logic [7:0] RST_PB = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // value returned for write-only registers, reserved bits and holes
    localparam logic [31:0] UNDEF_READ = 32'h0000_0000;

    // field positions of the serial routing register
    localparam int SER_CKE_HIGH_BIT = 0;
    localparam int SER_CKE_LOW_BIT = 1;
    localparam int SER_SYNC_SEL_BIT = 2;
    localparam int SER_RX_EN_BIT = 3;
    localparam int SER_TX_EN_BIT = 4;
    localparam int SER_W = 5;

    // htrans code whose upper bit marks an active transfer
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // serial routing controls, packed in field-position order
    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic sync_sel;
        logic clock_enable_low;
        logic clock_enable_high;
    } gpa_ser_s;

    // data phase bookkeeping of the bus slave
    typedef struct packed {
        logic wr_pend;
        logic rd_pend;
        logic [11:0] ofs;
    } gpa_bus_s;

    // complete state of the block
    typedef struct packed {
        logic [3:0] pa_otype;
        logic [3:0] pa_dir;
        logic [3:0] pa_data;
        logic [3:0] pa_pullup;
        gpa_ser_s ser;
        logic [7:0] pb_dir;
        logic [7:0] pb_data;
        logic [3:0] pa_meta;
        logic [3:0] pa_sync;
        logic [7:0] pb_meta;
        logic [7:0] pb_sync;
        gpa_bus_s bus;
        logic [31:0] hrdata;
        logic hreadyout;
    } gpa_state_s;

endpackage : gpa_pkg

// ---- logic/gpa_top.sv ----
// port a / port b pin control with an ahb-lite register slave
`timescale 1ns/1ns

// Operation
// - port a output-type bits 3:0, reset 0
// - output-type 1: open-drain, pull-up off
// - output-type 0: push-pull drive
// - output-type bits 7:4 read undefined
// - port a pins routed per control settings
// - pin a3: clock in, clock out, or gpio
// - pin a2: receive input when rx enabled
// - pin a1: transmit output when tx enabled
// - pin a0: direction bit only
// - port b direction register, resets to 0
// - port b direction 1 drives, 0 inputs
// - port b direction reads undefined
// - port b output data, reset 0
// - port b pin read is read-only
// - pin read: data if output, else pin
// - pin read reflects sampled pin levels
// - port a direction bits reset 0
// - pull-up bit enables pull-up on inputs
module gpa_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // port a pins
    input wire logic [3:0] pa_in,
    output logic [3:0] pa_out,
    output logic [3:0] pa_oe,
    output logic [3:0] pa_pullup_en,
    // port b pins
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe,
    // serial interface side
    input wire logic serial_clock_line_out,
    input wire logic serial_transmit_line,
    output logic serial_clock_line_in,
    output logic serial_receive_line,
    output logic clock_enable_high,
    output logic clock_enable_low,
    output logic sync_sel,
    output logic rx_enable,
    output logic tx_enable
);

    gpa_pkg::gpa_state_s st;
    gpa_pkg::gpa_state_s next_st;

    logic accept;
    logic [3:0] a_is_out;
    logic [3:0] a_val;
    logic [3:0] pa_pin_read;
    logic [7:0] pb_pin_read;
    logic [31:0] rd_mux;

    // hsize is not decoded: only whole-word transfers are supported
    assign accept = hsel && hready && htrans[1];

    // per-pin ownership and drive value for port a
    always_comb
    begin
        a_is_out = st.pa_dir;
        a_val = st.pa_data;
        if (st.ser.clock_enable_high)
        begin
            a_is_out[3] = 1'b0;
        end
        else if (st.ser.sync_sel || st.ser.clock_enable_low)
        begin
            a_is_out[3] = 1'b1;
            a_val[3] = serial_clock_line_out;
        end
        if (st.ser.rx_enable)
        begin
            a_is_out[2] = 1'b0;
        end
        if (st.ser.tx_enable)
        begin
            a_is_out[1] = 1'b1;
            a_val[1] = serial_transmit_line;
        end
    end
    // pin a0 keeps its direction bit

    // open-drain only ever pulls low; a high level is left to the pull-up outside
    assign pa_oe = a_is_out & (~st.pa_otype | ~a_val);
    assign pa_out = a_val & ~st.pa_otype;
    // an output pin never keeps its pull-up, which also covers open-drain
    assign pa_pullup_en = ~a_is_out & st.pa_pullup;

    assign pb_oe = st.pb_dir;
    assign pb_out = st.pb_data;

    assign serial_clock_line_in = st.pa_sync[3];
    assign serial_receive_line = st.pa_sync[2];
    assign clock_enable_high = st.ser.clock_enable_high;
    assign clock_enable_low = st.ser.clock_enable_low;
    assign sync_sel = st.ser.sync_sel;
    assign rx_enable = st.ser.rx_enable;
    assign tx_enable = st.ser.tx_enable;

    assign pa_pin_read = (st.pa_dir & st.pa_data) | (~st.pa_dir & st.pa_sync);
    assign pb_pin_read = (st.pb_dir & st.pb_data) | (~st.pb_dir & st.pb_sync);

    // read multiplexer; unmapped offsets and write-only registers give UNDEF_READ
    always_comb
    begin
        rd_mux = gpa_pkg::UNDEF_READ;
        case (st.bus.ofs)
            gpa_pkg::OFS_PA_OTYPE: rd_mux[3:0] = st.pa_otype;
            gpa_pkg::OFS_PA_DATA: rd_mux[3:0] = st.pa_data;
            gpa_pkg::OFS_PA_PULLUP: rd_mux[3:0] = st.pa_pullup;
            gpa_pkg::OFS_PA_PINS: rd_mux[3:0] = pa_pin_read;
            gpa_pkg::OFS_SER_ROUTE: rd_mux[gpa_pkg::SER_W-1:0] = st.ser;
            gpa_pkg::OFS_PB_DATA: rd_mux[7:0] = st.pb_data;
            gpa_pkg::OFS_PB_PINS: rd_mux[7:0] = pb_pin_read;
            default: rd_mux = gpa_pkg::UNDEF_READ;
        endcase
    end

    always_comb
    begin
        next_st = st;
        // two-flop synchronisers on every pin input
        next_st.pa_meta = pa_in;
        next_st.pa_sync = st.pa_meta;
        next_st.pb_meta = pb_in;
        next_st.pb_sync = st.pb_meta;
        // write data phase: hwdata is valid one cycle after the address
        if (st.bus.wr_pend)
        begin
            next_st.bus.wr_pend = 1'b0;
            case (st.bus.ofs)
                gpa_pkg::OFS_PA_OTYPE: next_st.pa_otype = hwdata[3:0];
                gpa_pkg::OFS_PA_DIR: next_st.pa_dir = hwdata[3:0];
                gpa_pkg::OFS_PA_DATA: next_st.pa_data = hwdata[3:0];
                gpa_pkg::OFS_PA_PULLUP: next_st.pa_pullup = hwdata[3:0];
                gpa_pkg::OFS_SER_ROUTE:
                    next_st.ser = gpa_pkg::gpa_ser_s'(hwdata[gpa_pkg::SER_W-1:0]);
                gpa_pkg::OFS_PB_DIR: next_st.pb_dir = hwdata[7:0];
                gpa_pkg::OFS_PB_DATA: next_st.pb_data = hwdata[7:0];
                default: next_st.bus.wr_pend = 1'b0;
            endcase
        end
        // read data phase: one wait state so a write just before is seen
        if (st.bus.rd_pend)
        begin
            next_st.hrdata = rd_mux;
            next_st.hreadyout = 1'b1;
            next_st.bus.rd_pend = 1'b0;
        end
        if (accept)
        begin
            next_st.bus.ofs = haddr[11:0];
            next_st.bus.wr_pend = hwrite;
            next_st.bus.rd_pend = !hwrite;
            next_st.hreadyout = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st.pa_otype <= gpa_pkg::RST_PA;
            st.pa_dir <= gpa_pkg::RST_PA;
            st.pa_data <= gpa_pkg::RST_PA;
            st.pa_pullup <= gpa_pkg::RST_PA;
            st.ser <= '0;
            st.pb_dir <= gpa_pkg::RST_PB;
            st.pb_data <= gpa_pkg::RST_PB;
            st.pa_meta <= gpa_pkg::RST_PA;
            st.pa_sync <= gpa_pkg::RST_PA;
            st.pb_meta <= gpa_pkg::RST_PB;
            st.pb_sync <= gpa_pkg::RST_PB;
            st.bus <= '0;
            st.hrdata <= gpa_pkg::RST_WORD;
            st.hreadyout <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign hreadyout = st.hreadyout;
    assign hrdata = st.hrdata;
    assign hresp = gpa_pkg::HRESP_OKAY;

    // checks

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_wr(logic [11:0] ofs);
        accept && hwrite && haddr[11:0] == ofs;
    endsequence

    sequence s_rd(logic [11:0] ofs);
        accept && !hwrite && haddr[11:0] == ofs;
    endsequence

    sequence s_rd_done;
        !hreadyout ##1 hreadyout;
    endsequence

    property p_otype_write;
        s_wr(gpa_pkg::OFS_PA_OTYPE) ##1 1'b1 |=> st.pa_otype == $past(hwdata[3:0]);
    endproperty
    a_otype_write: assert property (p_otype_write) else $error("output type not stored");

    property p_open_drain;
        ((pa_out & st.pa_otype) == 4'h0)
            && ((pa_oe & st.pa_otype & a_val) == 4'h0)
            && ((pa_pullup_en & a_is_out) == 4'h0);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain pin drove high");

    property p_push_pull;
        (a_is_out & ~st.pa_otype & ~pa_oe) == 4'h0;
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull pin not driven");

    property p_otype_reserved;
        s_rd(gpa_pkg::OFS_PA_OTYPE) |-> ##1 s_rd_done ##0 hrdata[31:4] == 28'h0000000;
    endproperty
    a_otype_reserved: assert property (p_otype_reserved) else $error("reserved bits set");

    property p_clock_in;
        st.ser.clock_enable_high |-> !pa_oe[3] && serial_clock_line_in == $past(pa_in[3], 2);
    endproperty
    a_clock_in: assert property (p_clock_in) else $error("clock pin not an input");

    property p_clock_out;
        !st.ser.clock_enable_high && (st.ser.sync_sel || st.ser.clock_enable_low)
            && !st.pa_otype[3] |-> pa_oe[3] && pa_out[3] == serial_clock_line_out;
    endproperty
    a_clock_out: assert property (p_clock_out) else $error("clock pin not driven");

    property p_receive;
        st.ser.rx_enable |-> !pa_oe[2] && serial_receive_line == $past(pa_in[2], 2);
    endproperty
    a_receive: assert property (p_receive) else $error("receive pin driven");

    property p_transmit;
        st.ser.tx_enable && !st.pa_otype[1] |-> pa_oe[1] && pa_out[1] == serial_transmit_line;
    endproperty
    a_transmit: assert property (p_transmit) else $error("transmit pin not driven");

    property p_pin_a0;
        pa_oe[0] == (st.pa_dir[0] && (!st.pa_otype[0] || !st.pa_data[0]));
    endproperty
    a_pin_a0: assert property (p_pin_a0) else $error("pin a0 enable wrong");

    property p_pb_dir_write;
        s_wr(gpa_pkg::OFS_PB_DIR) ##1 1'b1 |=> pb_oe == $past(hwdata[7:0]);
    endproperty
    a_pb_dir_write: assert property (p_pb_dir_write) else $error("direction not applied");

    property p_pb_dir_read;
        s_rd(gpa_pkg::OFS_PB_DIR) |-> ##1 s_rd_done ##0 hrdata == gpa_pkg::UNDEF_READ;
    endproperty
    a_pb_dir_read: assert property (p_pb_dir_read) else $error("direction readable");

    property p_pb_data_write;
        s_wr(gpa_pkg::OFS_PB_DATA) ##1 1'b1 |=> pb_out == $past(hwdata[7:0]);
    endproperty
    a_pb_data_write: assert property (p_pb_data_write) else $error("output data not applied");

    property p_pin_read_ro;
        s_wr(gpa_pkg::OFS_PB_PINS) ##1 1'b1 |=> $stable(st.pb_data) && $stable(st.pb_dir);
    endproperty
    a_pin_read_ro: assert property (p_pin_read_ro) else $error("pin read was written");

    property p_pin_read;
        s_rd(gpa_pkg::OFS_PB_PINS) |-> ##1 s_rd_done ##0 hrdata[7:0] == $past(pb_pin_read);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin read value wrong");

    // synchronisers restart from 0, so the first two edges after reset hold no pin level
    property p_pin_sample;
        $past(hresetn, 2) |-> (pb_pin_read & ~st.pb_dir) == ($past(pb_in, 2) & ~st.pb_dir);
    endproperty
    a_pin_sample: assert property (p_pin_sample) else $error("pin level not sampled");

    property p_pullup;
        pa_pullup_en == (~a_is_out & st.pa_pullup);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up state wrong");

    property p_od_release;
        (a_is_out & st.pa_otype & ~a_val & ~pa_oe) == 4'h0;
    endproperty
    a_od_release: assert property (p_od_release) else $error("open-drain low not driven");

    property p_override;
        st.ser.tx_enable && !st.pa_dir[1] && !st.pa_otype[1] |-> pa_oe[1];
    endproperty
    a_override: assert property (p_override) else $error("direction bit not overridden");

    property p_route_write;
        s_wr(gpa_pkg::OFS_SER_ROUTE) ##1 1'b1
            |=> {tx_enable, rx_enable, sync_sel, clock_enable_low, clock_enable_high}
                == $past(hwdata[gpa_pkg::SER_W-1:0]);
    endproperty
    a_route_write: assert property (p_route_write) else $error("routing not stored");

    property p_pa_dir_write;
        s_wr(gpa_pkg::OFS_PA_DIR) ##1 1'b1 |=> st.pa_dir == $past(hwdata[3:0]);
    endproperty
    a_pa_dir_write: assert property (p_pa_dir_write) else $error("port a direction lost");

    property p_pullup_write;
        s_wr(gpa_pkg::OFS_PA_PULLUP) ##1 1'b1 |=> st.pa_pullup == $past(hwdata[3:0]);
    endproperty
    a_pullup_write: assert property (p_pullup_write) else $error("pull-up bits lost");

    property p_pin_read_out;
        (pb_pin_read & st.pb_dir) == (pb_out & pb_oe);
    endproperty
    a_pin_read_out: assert property (p_pin_read_out) else $error("output bit not read back");

    property p_od_transmit;
        st.ser.tx_enable && st.pa_otype[1] |-> !pa_out[1] && pa_oe[1] == !serial_transmit_line;
    endproperty
    a_od_transmit: assert property (p_od_transmit) else $error("open-drain transmit wrong");

endmodule : gpa_top

// ---- tb/gpa_pins.sv ----
// model of the external circuitry on the port a and port b pins
`timescale 1ns/1ns
module gpa_pins (
    // clock
    input wire logic hclk,
    // device drivers
    input wire logic [3:0] pa_out,
    input wire logic [3:0] pa_oe,
    input wire logic [3:0] pa_pullup_en,
    input wire logic [7:0] pb_out,
    input wire logic [7:0] pb_oe,
    // outside drivers
    input wire logic [3:0] ext_a,
    input wire logic [3:0] ext_a_en,
    input wire logic [7:0] ext_b,
    input wire logic [7:0] ext_b_en,
    // resolved pin levels
    output logic [3:0] pa_in,
    output logic [7:0] pb_in
);
    logic [7:0] wobble = 8'h5A;

    // a floating pin has no level; toggling keeps it from passing for a match
    always @(posedge hclk)
        wobble <= ~wobble;

    assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a_en & ext_a)
        | (~pa_oe & ~ext_a_en & (pa_pullup_en | wobble[3:0]));
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b_en & ext_b)
        | (~pb_oe & ~ext_b_en & wobble);
endmodule : gpa_pins

// ---- tb/gpa_top_tb.sv ----
// self-checking bench for the port a / port b pin block
`timescale 1ns/1ns
module gpa_top_tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, scl_out, tx_line, scl_in, rxd;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] pa_in, pa_out, pa_oe, pa_pu, ext_a, ext_a_en;
    logic [7:0] pb_in, pb_out, pb_oe, ext_b, ext_b_en;
    logic [4:0] route;
    int n_errors, comparisons;

    gpa_top u_gpa_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup_en(pa_pu),
        .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .serial_clock_line_out(scl_out),
        .serial_transmit_line(tx_line), .serial_clock_line_in(scl_in),
        .serial_receive_line(rxd), .clock_enable_high(route[0]),
        .clock_enable_low(route[1]), .sync_sel(route[2]), .rx_enable(route[3]),
        .tx_enable(route[4]));

    gpa_pins u_gpa_pins (.hclk(hclk), .pa_out(pa_out), .pa_oe(pa_oe),
        .pa_pullup_en(pa_pu), .pb_out(pb_out), .pb_oe(pb_oe), .ext_a(ext_a),
        .ext_a_en(ext_a_en), .ext_b(ext_b), .ext_b_en(ext_b_en), .pa_in(pa_in),
        .pb_in(pb_in));

    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // hready is looked at mid-cycle, where it already holds the edge's value
    task automatic wait_rdy();
        int n;
        logic ok;
        n = 0;
        do
        begin
            @(negedge hclk);
            ok = hreadyout;
            rd = hrdata;
            n++;
            @(posedge hclk);
        end
        while (ok !== 1'b1 && n < 20);
        if (ok !== 1'b1)
        begin
            n_errors++;
            summarize();
        end
    endtask : wait_rdy

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        htrans <= gpa_pkg::HTRANS_NONSEQ;
        haddr <= {20'h0, a};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask : rdchk

    task automatic t_reset();
        rdchk(gpa_pkg::OFS_PA_OTYPE, 32'h0, "otype");
        rdchk(gpa_pkg::OFS_PB_DIR, 32'h0, "pb dir");
        rdchk(gpa_pkg::OFS_PB_DATA, 32'h0, "pb data");
        rdchk(gpa_pkg::OFS_PB_PINS, 32'h96, "pb pins");
        check("oe", 32'({pa_oe, pb_oe}), 32'h0);
        check("hresp", 32'(hresp), 32'(gpa_pkg::HRESP_OKAY));
        wr(gpa_pkg::OFS_PA_OTYPE, 32'hFFFF_FFFF);
        rdchk(gpa_pkg::OFS_PA_OTYPE, 32'h0F, "otype");
        wr(gpa_pkg::OFS_PA_OTYPE, 32'h0);
        $display("reset and output type test done");
    endtask : t_reset

    task automatic t_port_b();
        ext_b <= 8'h03;
        ext_b_en <= 8'h0F;
        wr(gpa_pkg::OFS_PB_DIR, 32'hF0);
        wr(gpa_pkg::OFS_PB_DATA, 32'hA5);
        @(negedge hclk);
        check("pb oe", 32'(pb_oe), 32'hF0);
        check("pb out", 32'(pb_out), 32'hA5);
        rdchk(gpa_pkg::OFS_PB_PINS, 32'hA3, "pb pins");
        rdchk(gpa_pkg::OFS_PB_DIR, 32'h0, "pb dir");
        wr(gpa_pkg::OFS_PB_PINS, 32'hFF);
        rdchk(gpa_pkg::OFS_PB_PINS, 32'hA3, "pb pins");
        rdchk(gpa_pkg::OFS_PB_DATA, 32'hA5, "pb data");
        ext_b <= 8'h3C;
        ext_b_en <= 8'hF0;
        wr(gpa_pkg::OFS_PB_DIR, 32'h0F);
        rdchk(gpa_pkg::OFS_PB_PINS, 32'h35, "pb pins");
        $display("port b test done");
    endtask : t_port_b

    task automatic t_drive();
        wr(gpa_pkg::OFS_PA_DIR, 32'hF);
        wr(gpa_pkg::OFS_PA_DATA, 32'h5);
        @(negedge hclk);
        check("pa oe", 32'(pa_oe), 32'hF);
        check("pa out", 32'(pa_out), 32'h5);
        wr(gpa_pkg::OFS_PA_OTYPE, 32'hF);
        wr(gpa_pkg::OFS_PA_PULLUP, 32'hF);
        @(negedge hclk);
        check("od oe", 32'(pa_oe), 32'hA);
        check("od out", 32'(pa_out & pa_oe), 32'h0);
        check("od pullup", 32'(pa_pu), 32'h0);
        wr(gpa_pkg::OFS_PA_DIR, 32'h0);
        @(negedge hclk);
        check("pullup", 32'(pa_pu), 32'hF);
        wr(gpa_pkg::OFS_PA_OTYPE, 32'h0);
        wr(gpa_pkg::OFS_PA_PULLUP, 32'h0);
        wr(gpa_pkg::OFS_PA_DATA, 32'h0);
        $display("port a drive test done");
    endtask : t_drive

    // gpio data is 0 and the serial unit drives 1, so out shows who owns a pin
    task automatic route_case(input logic [4:0] ser, input logic [3:0] dir,
        input logic [3:0] oe, input logic [3:0] out);
        wr(gpa_pkg::OFS_SER_ROUTE, 32'(ser));
        wr(gpa_pkg::OFS_PA_DIR, 32'(dir));
        @(negedge hclk);
        check("routing", 32'(route), 32'(ser));
        check("pa oe", 32'(pa_oe), 32'(oe));
        check("pa out", 32'(pa_out & oe), 32'(out));
    endtask : route_case

    task automatic t_route();
        route_case(5'h01, 4'hF, 4'h7, 4'h0);
        route_case(5'h03, 4'h0, 4'h0, 4'h0);
        route_case(5'h02, 4'h0, 4'h8, 4'h8);
        route_case(5'h04, 4'h0, 4'h8, 4'h8);
        route_case(5'h08, 4'hF, 4'hB, 4'h0);
        route_case(5'h10, 4'h0, 4'h2, 4'h2);
        route_case(5'h00, 4'h5, 4'h5, 4'h0);
        wr(gpa_pkg::OFS_PA_OTYPE, 32'h2);
        route_case(5'h10, 4'h0, 4'h0, 4'h0);
        @(posedge hclk);
        tx_line <= 1'b0;
        route_case(5'h10, 4'h0, 4'h2, 4'h0);
        @(posedge hclk);
        tx_line <= 1'b1;
        ext_a <= 4'hC;
        ext_a_en <= 4'hC;
        wr(gpa_pkg::OFS_PA_OTYPE, 32'h0);
        route_case(5'h09, 4'h0, 4'h0, 4'h0);
        rdchk(gpa_pkg::OFS_SER_ROUTE, 32'h09, "route");
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        check("serial in", 32'({scl_in, rxd}), 32'h3);
        @(posedge hclk);
        ext_a <= 4'h0;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        check("serial in", 32'({scl_in, rxd}), 32'h0);
        $display("routing test done");
    endtask : t_route

    // reset in mid-run must bring back the values after reset
    task automatic t_mid_reset();
        wr(gpa_pkg::OFS_PB_DATA, 32'h5A);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        check("pb out", 32'(pb_out), 32'(gpa_pkg::RST_PB));
        check("pb oe", 32'(pb_oe), 32'(gpa_pkg::RST_PB));
        check("route", 32'(route), 32'h0);
        rdchk(gpa_pkg::OFS_PB_DATA, 32'h0, "pb data");
        $display("mid-run reset test done");
    endtask : t_mid_reset

    initial
    begin
        n_errors = 0;
        comparisons = 0;
        hresetn = 1'b0;
        hsel = 1'b1;
        hsize = 3'h2;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        scl_out = 1'b1;
        tx_line = 1'b1;
        ext_a = 4'h0;
        ext_a_en = 4'h0;
        ext_b = 8'h96;
        ext_b_en = 8'hFF;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_port_b();
        t_drive();
        t_route();
        t_mid_reset();
        summarize();
    end
endmodule : gpa_top_tb
